/* File: src/crypto_capability_config.sv */
/*
 * read-only capability and status bank of the crypto engine on apb,
 * plus the admission check applied to each incoming request.
 * assumes a single pclk domain; request fields come from same-clock logic.
 */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/100ps
`include "crypto_caps_cfg.svh"

module crypto_capability_config
    import crypto_caps_pkg::*;
#(
    parameter logic [3:0] SERVICES = 4'hf,
    parameter logic [63:0] CIPHER_ALGOS = 64'h0000_0000_0000_7fff,
    parameter logic [31:0] DIGEST_ALGOS = 32'h0000_1fff,
    parameter logic [63:0] AUTH_ALGOS = 64'h0026_0600_1e00_007f,
    parameter logic [31:0] AUTHENC_ALGOS = 32'h0000_000f,
    parameter logic [31:0] DATA_QUEUES = 32'h0000_0001,
    parameter logic [31:0] CIPHER_KEY_MAX = 32'h0000_0040,
    parameter logic [31:0] AUTH_KEY_MAX = 32'h0000_0080,
    parameter logic [63:0] REQ_SIZE_MAX = 64'h0000_0000_0001_0000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // engine control
    input wire logic engine_halt,
    output logic engine_ready_flag,
    // request admission
    input wire logic req_valid,
    input wire logic [1:0] req_service,
    input wire logic [5:0] req_algo,
    input wire logic [63:0] req_size,
    input wire logic [31:0] req_key_len,
    input wire logic [31:0] req_auth_key_len,
    output logic resp_valid,
    output logic resp_fail
);

    localparam logic [7:0] READY_CYC = 8'(`READY_DELAY_CYC);
    // defined-code masks as sized constants so their words can be sliced
    localparam logic [63:0] CIPHER_DEF = `DEF_CIPHER_CODES;
    localparam logic [31:0] DIGEST_DEF = `DEF_DIGEST_CODES;
    localparam logic [63:0] AUTH_DEF = `DEF_AUTH_CODES;
    localparam logic [31:0] AUTHENC_DEF = `DEF_AUTHENC_CODES;

    // published capability words; algorithm masks trimmed to defined codes
    logic [3:0] svc;
    logic [63:0] cipher_word;
    logic [31:0] digest_word;
    logic [63:0] auth_word;
    logic [31:0] authenc_word;
    logic [31:0] queue_word;
    logic [31:0] cipher_key_word;
    logic [31:0] auth_key_word;

    // only services with at least one real algorithm are advertised
    assign svc[`SVC_CIPHER] = SERVICES[`SVC_CIPHER]
        && ((CIPHER_ALGOS & `DEF_CIPHER_CODES) != 64'h0);
    assign svc[`SVC_DIGEST] = SERVICES[`SVC_DIGEST]
        && ((DIGEST_ALGOS & `DEF_DIGEST_CODES) != 32'h0);
    assign svc[`SVC_AUTH] = SERVICES[`SVC_AUTH]
        && ((AUTH_ALGOS & `DEF_AUTH_CODES) != 64'h0);
    assign svc[`SVC_AUTHENC] = SERVICES[`SVC_AUTHENC]
        && ((AUTHENC_ALGOS & `DEF_AUTHENC_CODES) != 32'h0);

    // masks of services not offered read zero
    assign cipher_word = svc[`SVC_CIPHER] ? (CIPHER_ALGOS & `DEF_CIPHER_CODES)
        : 64'h0;
    assign digest_word = svc[`SVC_DIGEST] ? (DIGEST_ALGOS & `DEF_DIGEST_CODES)
        : 32'h0;
    assign auth_word = svc[`SVC_AUTH] ? (AUTH_ALGOS & `DEF_AUTH_CODES)
        : 64'h0;
    assign authenc_word = svc[`SVC_AUTHENC] ? (AUTHENC_ALGOS & `DEF_AUTHENC_CODES)
        : 32'h0;

    // a bad parameter never yields an illegal queue count
    assign queue_word = (DATA_QUEUES < `QUEUE_MIN) ? `QUEUE_MIN
        : (DATA_QUEUES > `QUEUE_MAX) ? `QUEUE_MAX : DATA_QUEUES;
    // authenticated encryption keys share the cipher limit
    assign cipher_key_word = (svc[`SVC_CIPHER] || svc[`SVC_AUTHENC])
        ? CIPHER_KEY_MAX : 32'h0;
    assign auth_key_word = svc[`SVC_AUTH] ? AUTH_KEY_MAX : 32'h0;

    // ready sequencer: flag rises after a fixed settle time
    ready_state_t state;
    logic [7:0] settle_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 8'h00;
        end else if (state == ST_SETTLE && settle_cnt != READY_CYC) begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_SETTLE;
        end else begin
            case (state)
                ST_SETTLE: begin
                    if (engine_halt) begin
                        state <= ST_HALTED;
                    end else if (settle_cnt == READY_CYC) begin
                        state <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (engine_halt) begin
                        state <= ST_HALTED;
                    end
                end
                // only a reset leaves halt, matching the driver's recovery
                ST_HALTED: begin
                    state <= ST_HALTED;
                end
                default: begin
                    state <= ST_SETTLE;
                end
            endcase
        end
    end

    // flag is driven by hardware only; bus writes never reach it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engine_ready_flag <= 1'b0;
        end else begin
            engine_ready_flag <= (state == ST_READY) && !engine_halt;
        end
    end

    // apb: one wait-free access, answer prepared in the setup cycle
    logic setup;
    logic [31:0] next_rdata;
    logic next_err;

    assign setup = psel && !penable;

    always_comb begin
        next_rdata = 32'h0;
        next_err = 1'b0;
        if (paddr == `OFS_DEVICE_STATUS) begin
            next_rdata = {31'h0, engine_ready_flag};
        end else if (paddr == `OFS_DATA_QUEUE_LIMIT) begin
            next_rdata = queue_word;
        end else if (paddr == `OFS_SERVICE_MASK) begin
            next_rdata = {28'h0, svc};
        end else if (paddr == `OFS_CIPHER_MASK_LOW) begin
            next_rdata = cipher_word[31:0];
        end else if (paddr == `OFS_CIPHER_MASK_HIGH) begin
            next_rdata = cipher_word[63:32];
        end else if (paddr == `OFS_DIGEST_MASK) begin
            next_rdata = digest_word;
        end else if (paddr == `OFS_AUTH_MASK_LOW) begin
            next_rdata = auth_word[31:0];
        end else if (paddr == `OFS_AUTH_MASK_HIGH) begin
            next_rdata = auth_word[63:32];
        end else if (paddr == `OFS_AUTHENC_MASK) begin
            next_rdata = authenc_word;
        end else if (paddr == `OFS_CIPHER_KEY_LIMIT) begin
            next_rdata = cipher_key_word;
        end else if (paddr == `OFS_AUTH_KEY_LIMIT) begin
            next_rdata = auth_key_word;
        end else if (paddr == `OFS_SPARE_WORD) begin
            next_rdata = 32'h0;
        end else if (paddr == `OFS_SIZE_LIMIT_LOW) begin
            next_rdata = REQ_SIZE_MAX[31:0];
        end else if (paddr == `OFS_SIZE_LIMIT_HIGH) begin
            next_rdata = REQ_SIZE_MAX[63:32];
        end else begin
            next_err = 1'b1;
        end
        // writes carry no data back and change nothing
        if (pwrite) begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // read path has no side effects: no state is touched by decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= next_rdata;
            pslverr <= next_err;
        end else begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
    end

    // request admission: algorithm, size and key checks
    logic algo_ok;
    logic size_ok;
    logic key_ok;
    logic next_fail;

    always_comb begin
        algo_ok = 1'b0;
        case (req_service)
            `SVC_CIPHER: algo_ok = cipher_word[req_algo];
            `SVC_DIGEST: algo_ok = !req_algo[5] && digest_word[req_algo[4:0]];
            `SVC_AUTH: algo_ok = auth_word[req_algo];
            `SVC_AUTHENC: algo_ok = !req_algo[5] && authenc_word[req_algo[4:0]];
            default: algo_ok = 1'b0;
        endcase
    end

    assign size_ok = req_size <= REQ_SIZE_MAX;
    // cipher and authenc keys against one limit, auth keys the other
    assign key_ok = (req_service == `SVC_AUTH) ? (req_auth_key_len <= auth_key_word)
        : (req_service == `SVC_DIGEST) ? 1'b1 : (req_key_len <= cipher_key_word);
    assign next_fail = !engine_ready_flag || !svc[req_service] || !algo_ok
        || !size_ok || !key_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_valid <= 1'b0;
            resp_fail <= 1'b0;
        end else begin
            resp_valid <= req_valid;
            resp_fail <= req_valid && next_fail;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // status word and ready sequencing
    a_status_clean: assert property (setup && !pwrite && paddr == `OFS_DEVICE_STATUS
        |=> prdata[31:1] == 31'h0 && prdata[0] == $past(engine_ready_flag))
        else $error("status word shows an undefined flag or wrong ready bit");
    a_ready_settle: assert property ($rose(engine_ready_flag)
        |-> $past(settle_cnt, 2) == READY_CYC)
        else $error("ready flag rose before settle time");
    a_ready_held: assert property (engine_ready_flag && !engine_halt
        |=> engine_ready_flag)
        else $error("ready flag dropped without halt");
    a_halt_drops: assert property (engine_halt |=> !engine_ready_flag [*3])
        else $error("ready flag stayed up during halt");

    // capability words
    a_service_word: assert property (setup && !pwrite && paddr == `OFS_SERVICE_MASK
        |=> prdata[31:4] == 28'h0 && (prdata[3:0] & ~SERVICES) == 4'h0
            && prdata[0] == (SERVICES[0] && (CIPHER_ALGOS & CIPHER_DEF) != 64'h0)
            && prdata[1] == (SERVICES[1] && (DIGEST_ALGOS & DIGEST_DEF) != 32'h0)
            && prdata[2] == (SERVICES[2] && (AUTH_ALGOS & AUTH_DEF) != 64'h0)
            && prdata[3] == (SERVICES[3] && (AUTHENC_ALGOS & AUTHENC_DEF) != 32'h0))
        else $error("service word wrong");
    a_cipher_low: assert property (setup && !pwrite && paddr == `OFS_CIPHER_MASK_LOW
        |=> prdata == (svc[`SVC_CIPHER] ? (CIPHER_ALGOS[31:0] & CIPHER_DEF[31:0]) : 32'h0))
        else $error("cipher mask low word wrong");
    a_cipher_high: assert property (setup && !pwrite && paddr == `OFS_CIPHER_MASK_HIGH
        |=> (prdata & ~CIPHER_DEF[63:32]) == 32'h0)
        else $error("undefined cipher code advertised");
    a_digest_word: assert property (setup && !pwrite && paddr == `OFS_DIGEST_MASK
        |=> prdata == (svc[`SVC_DIGEST] ? (DIGEST_ALGOS & DIGEST_DEF) : 32'h0))
        else $error("hash mask wrong");
    a_auth_low: assert property (setup && !pwrite && paddr == `OFS_AUTH_MASK_LOW
        |=> (prdata & ~AUTH_DEF[31:0]) == 32'h0)
        else $error("undefined authentication code advertised");
    a_auth_high: assert property (setup && !pwrite && paddr == `OFS_AUTH_MASK_HIGH
        |=> prdata == (svc[`SVC_AUTH] ? (AUTH_ALGOS[63:32] & AUTH_DEF[63:32]) : 32'h0))
        else $error("authentication mask high word wrong");
    a_authenc_word: assert property (setup && !pwrite && paddr == `OFS_AUTHENC_MASK
        |=> prdata == (svc[`SVC_AUTHENC] ? (AUTHENC_ALGOS & AUTHENC_DEF) : 32'h0))
        else $error("authenticated encryption mask wrong");
    a_queue_range: assert property (setup && !pwrite && paddr == `OFS_DATA_QUEUE_LIMIT
        |=> prdata >= `QUEUE_MIN && prdata <= `QUEUE_MAX)
        else $error("queue limit out of range");
    a_cipher_key: assert property (setup && !pwrite && paddr == `OFS_CIPHER_KEY_LIMIT
        && svc[`SVC_CIPHER] |=> prdata == CIPHER_KEY_MAX)
        else $error("cipher key limit wrong");
    a_auth_key: assert property (setup && !pwrite && paddr == `OFS_AUTH_KEY_LIMIT
        && svc[`SVC_AUTH] |=> prdata == AUTH_KEY_MAX)
        else $error("authentication key limit wrong");
    a_spare_zero: assert property (setup && !pwrite && paddr == `OFS_SPARE_WORD
        |=> prdata == 32'h0 && !pslverr)
        else $error("spare word not zero");
    a_size_low: assert property (setup && !pwrite && paddr == `OFS_SIZE_LIMIT_LOW
        |=> prdata == REQ_SIZE_MAX[31:0])
        else $error("size limit low word wrong");
    a_size_high: assert property (setup && !pwrite && paddr == `OFS_SIZE_LIMIT_HIGH
        |=> prdata == REQ_SIZE_MAX[63:32])
        else $error("size limit high word wrong");

    // bus answers
    a_write_ignored: assert property (setup && pwrite && !next_err
        |=> pready && !pslverr && prdata == 32'h0 ##1 !pready)
        else $error("write not completed as ignored");
    a_read_answer: assert property (setup
        |=> pready ##1 !pready && prdata == 32'h0 && !pslverr)
        else $error("bus answer did not last exactly one cycle");

    // request admission
    a_idle_quiet: assert property (!req_valid
        |=> !resp_valid && !resp_fail)
        else $error("response without a request");
    a_not_ready_fail: assert property (req_valid && !engine_ready_flag
        |=> resp_valid && resp_fail)
        else $error("request accepted before ready");
    a_bad_algo_fail: assert property (req_valid && req_service == `SVC_CIPHER
        && !CIPHER_DEF[req_algo] |=> resp_fail)
        else $error("undefined cipher code accepted");
    a_oversize_fail: assert property (req_valid && req_size > REQ_SIZE_MAX
        |=> resp_fail)
        else $error("oversized request not failed");
    a_key_fail: assert property (req_valid && req_service == `SVC_CIPHER
        && req_key_len > CIPHER_KEY_MAX |=> resp_fail)
        else $error("long cipher key not failed");
    a_auth_key_fail: assert property (req_valid && req_service == `SVC_AUTH
        && req_auth_key_len > AUTH_KEY_MAX |=> resp_fail)
        else $error("long authentication key not failed");
    a_good_pass: assert property (req_valid && engine_ready_flag
        && req_service == `SVC_DIGEST && svc[`SVC_DIGEST]
        && digest_word[req_algo[4:0]] && !req_algo[5] && size_ok
        |=> resp_valid && !resp_fail)
        else $error("valid hash request failed");

    c_ready_up: cover property ($rose(engine_ready_flag));
    c_halt_seen: cover property ($fell(engine_ready_flag));
    c_read_caps: cover property (setup && !pwrite && paddr == `OFS_CIPHER_MASK_LOW);
    c_req_pass: cover property (resp_valid && !resp_fail);
    c_bad_addr: cover property (pready && pslverr);

endmodule

/* File: src/crypto_caps_cfg.svh */
/*
 * offsets, field layouts, defined-code masks and timing counts of the
 * capability register bank.
 * assumes a 50 MHz pclk and a 32-bit apb master on the far side.
 */
`ifndef CRYPTO_CAPS_CFG_SVH
`define CRYPTO_CAPS_CFG_SVH

`define OFS_DEVICE_STATUS 12'h000
`define OFS_DATA_QUEUE_LIMIT 12'h004
`define OFS_SERVICE_MASK 12'h008
`define OFS_CIPHER_MASK_LOW 12'h00c
`define OFS_CIPHER_MASK_HIGH 12'h010
`define OFS_DIGEST_MASK 12'h014
`define OFS_AUTH_MASK_LOW 12'h018
`define OFS_AUTH_MASK_HIGH 12'h01c
`define OFS_AUTHENC_MASK 12'h020
`define OFS_CIPHER_KEY_LIMIT 12'h024
`define OFS_AUTH_KEY_LIMIT 12'h028
`define OFS_SPARE_WORD 12'h02c
`define OFS_SIZE_LIMIT_LOW 12'h030
`define OFS_SIZE_LIMIT_HIGH 12'h034

`define SVC_CIPHER 2'd0
`define SVC_DIGEST 2'd1
`define SVC_AUTH 2'd2
`define SVC_AUTHENC 2'd3
`define READY_FLAG_BIT 0

`define DEF_SERVICES 4'hf
`define DEF_CIPHER_CODES 64'h0000_0000_0000_7fff
`define DEF_DIGEST_CODES 32'h0000_1fff
`define DEF_AUTH_CODES 64'h0026_0600_1e00_007f
`define DEF_AUTHENC_CODES 32'h0000_000f
`define QUEUE_MIN 32'h0000_0001
`define QUEUE_MAX 32'h0000_ffff

`define CLK_PERIOD_NS 20
`define READY_DELAY_NS 1000
`define READY_DELAY_CYC ((`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: src/crypto_caps_pkg.sv */
/*
 * types of the capability register bank.
 * assumes crypto_caps_cfg.svh supplies the numbers.
 */
package crypto_caps_pkg;
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_READY,
        ST_HALTED
    } ready_state_t;
endpackage

/* File: sim/crypto_capability_config_tb.sv */
/*
 * self-checking bench of the capability register bank: apb reads and
 * writes, ready timing, halt, and request admission against a model.
 * assumes the bank's header and package are compiled first.
 */
`timescale 1ns/100ps
`include "crypto_caps_cfg.svh"

module crypto_capability_config_tb;
    import crypto_caps_pkg::*;
    // odd values on purpose: undefined code bits and a zero queue count
    localparam logic [3:0] SERVICES = 4'hf;
    localparam logic [63:0] CIPHER_ALGOS = 64'h0000_0001_0000_7ffe;
    localparam logic [31:0] DIGEST_ALGOS = 32'hffff_ffff;
    localparam logic [63:0] AUTH_ALGOS = 64'hffff_ffff_ffff_ffff;
    localparam logic [31:0] AUTHENC_ALGOS = 32'h0000_0000;
    localparam logic [31:0] DATA_QUEUES = 32'h0000_0000;
    localparam logic [31:0] CK = 32'h0000_0040;
    localparam logic [31:0] AK = 32'h0000_0080;
    localparam logic [63:0] SZ = 64'h0000_0000_0001_0000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, req_key_len, req_auth_key_len;
    logic [3:0] pstrb, svc;
    logic engine_halt, engine_ready_flag, req_valid, resp_valid, resp_fail;
    logic [1:0] req_service;
    logic [5:0] req_algo;
    logic [63:0] req_size;
    logic [63:0] m [4];
    logic [31:0] ew [14];
    logic [31:0] rd;
    logic err;
    int n_errors = 0, num_checks = 0, seed = 53, cnt;
    bit rdy = 0;

    crypto_capability_config #(.SERVICES(SERVICES), .CIPHER_ALGOS(CIPHER_ALGOS),
        .DIGEST_ALGOS(DIGEST_ALGOS), .AUTH_ALGOS(AUTH_ALGOS), .AUTHENC_ALGOS(AUTHENC_ALGOS),
        .DATA_QUEUES(DATA_QUEUES), .CIPHER_KEY_MAX(CK), .AUTH_KEY_MAX(AK),
        .REQ_SIZE_MAX(SZ)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_halt(engine_halt),
        .engine_ready_flag(engine_ready_flag), .req_valid(req_valid),
        .req_service(req_service), .req_algo(req_algo), .req_size(req_size),
        .req_key_len(req_key_len), .req_auth_key_len(req_auth_key_len),
        .resp_valid(resp_valid), .resp_fail(resp_fail));

    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // holds the request until pready is seen high, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic read_all;
        ew[0] = {31'h0, rdy};
        for (int i = 0; i < 14; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("register word", rd, ew[i]);
            chk("mapped error", err, 1'b0);
        end
    endtask

    task automatic send(input logic [1:0] s, input logic [5:0] a, input logic [63:0] sz,
            input logic [31:0] k, input logic [31:0] ak);
        bit f;
        f = !rdy || !svc[s] || !m[s][a] || sz > SZ || ((s == 0 || s == 3) && k > CK)
            || (s == 2 && ak > AK);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_service <= s;
        req_algo <= a;
        req_size <= sz;
        req_key_len <= k;
        req_auth_key_len <= ak;
        @(posedge pclk);
        req_valid <= 1'b0;
        @(posedge pclk);
        chk("response valid", resp_valid, 1'b1);
        chk("response fail", resp_fail, f);
    endtask

    // ready must come after the settle delay, not before and not much later
    task automatic do_reset;
        presetn <= 1'b0;
        engine_halt <= 1'b0;
        rdy = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (engine_ready_flag !== 1'b1 && cnt < 200);
        // flag rises two edges after the settle count ends, seen one edge later
        chk("ready delay", cnt, `READY_DELAY_CYC + 3);
        rdy = 1;
        apb(1'b0, `OFS_DEVICE_STATUS, 32'h0);
        chk("status after reset", rd, 32'h1);
    endtask

    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 4'hf;
        req_valid = 0;
        req_service = 0;
        req_algo = 0;
        req_size = 0;
        req_key_len = 0;
        req_auth_key_len = 0;
        m[0] = CIPHER_ALGOS & `DEF_CIPHER_CODES;
        m[1] = {32'h0, DIGEST_ALGOS & `DEF_DIGEST_CODES};
        m[2] = AUTH_ALGOS & `DEF_AUTH_CODES;
        m[3] = {32'h0, AUTHENC_ALGOS & `DEF_AUTHENC_CODES};
        for (int s = 0; s < 4; s++) begin
            svc[s] = SERVICES[s] && (m[s] != 64'h0);
            if (!svc[s])
                m[s] = 64'h0;
        end
        ew[1] = (DATA_QUEUES < `QUEUE_MIN) ? `QUEUE_MIN :
            (DATA_QUEUES > `QUEUE_MAX) ? `QUEUE_MAX : DATA_QUEUES;
        ew[2] = {28'h0, svc};
        ew[3] = m[0][31:0];
        ew[4] = m[0][63:32];
        ew[5] = m[1][31:0];
        ew[6] = m[2][31:0];
        ew[7] = m[2][63:32];
        ew[8] = m[3][31:0];
        ew[9] = (svc[0] || svc[3]) ? CK : 32'h0;
        ew[10] = svc[2] ? AK : 32'h0;
        ew[11] = 32'h0;
        ew[12] = SZ[31:0];
        ew[13] = SZ[63:32];
        do_reset;
        read_all;
        $display("test reads done");
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, 12'(i * 4), ~ew[i]);
            chk("write error", err, 1'b0);
            chk("write data", rd, 32'h0);
        end
        read_all;
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, `OFS_SIZE_LIMIT_HIGH + 12'h004 + 12'(i * 12'h7c4), 32'h0);
            chk("unmapped error", err, 1'b1);
            chk("unmapped data", rd, 32'h0);
        end
        $display("test writes done");
        for (int s = 0; s < 4; s++) begin
            send(2'(s), 6'h01, SZ, CK, AK);
            send(2'(s), 6'h01, SZ + 1, CK, AK);
            send(2'(s), 6'h01, SZ, CK + 1, AK);
            send(2'(s), 6'h01, SZ, CK, AK + 1);
            send(2'(s), 6'h00, SZ, CK, AK);
        end
        for (int i = 0; i < 60; i++)
            send(2'($random(seed)), 6'($random(seed)), SZ - 2 + 64'($random(seed) & 3),
                CK - 1 + 32'($random(seed) & 3), AK - 1 + 32'($random(seed) & 3));
        $display("test requests done");
        engine_halt <= 1'b1;
        repeat (3) @(posedge pclk);
        rdy = 0;
        chk("ready after halt", engine_ready_flag, 1'b0);
        apb(1'b0, `OFS_DEVICE_STATUS, 32'h0);
        chk("status halted", rd, 32'h0);
        send(2'd0, 6'h01, SZ, CK, AK);
        do_reset;
        read_all;
        send(2'd2, 6'h35, SZ, CK, AK);
        $display("test halt and reset done");
        wrap_up;
    end

    // whole run is well under 2000 cycles
    initial begin
        repeat (6000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end
endmodule
